// ### ppfm_mux.v
// Pin function multiplexer for ports P, J, M, S and T with flash strap capture.
//
// Function
// - Port P inputs raise keypad wake interrupt.
// - Port J 7:6 inputs raise keypad wake.
// - Capture port_p_bit6 at reset release.
// - Emulation modes: high strap clears visibility.
// - Normal expanded: low strap clears visibility.
// - Strap role only in expanded modes.
// - Opposite levels set; single-chip always sets.
// - Port P 5:0 carry pulse-width outputs.
// - Port T 7:5 carry timer channels.
// - Port T 4:0 timer or pulse-width.
// - Port M4 MOSI, out when master.
// - Port M2 MISO, out when slave.
// - Port M5 SPI clock, M3 select.
// - Port M1/M0 CAN transmit/receive if present.
// - Port S1/S0 serial transmit/receive.
// - Port S3:2 general I/O only.
`timescale 1ns/1ps
`include "ppfm_regs.vh"
module ppfm_mux (
    input wire mclk,
    input wire rstn,
    input wire [2:0] mode,
    // General I/O settings: data, direction (1 = output) and pad input per port.
    input wire [7:0] gp_p_data,
    input wire [7:0] gp_p_dir,
    input wire [7:0] pad_p_in,
    input wire [7:6] gp_j_data,
    input wire [7:6] gp_j_dir,
    input wire [7:6] pad_j_in,
    input wire [5:0] gp_m_data,
    input wire [5:0] gp_m_dir,
    input wire [5:0] pad_m_in,
    input wire [3:0] gp_s_data,
    input wire [3:0] gp_s_dir,
    input wire [3:0] pad_s_in,
    input wire [7:0] gp_t_data,
    input wire [7:0] gp_t_dir,
    input wire [7:0] pad_t_in,
    // Keypad wake enables.
    input wire [7:0] keypad_wake_p_en,
    input wire [7:6] keypad_wake_j_en,
    // Pulse-width module.
    input wire [5:0] pwp_en,
    input wire [4:0] pwt_en,
    input wire [5:0] pulse_width_out,
    // Timer channels.
    input wire [7:0] tim_en,
    input wire [7:0] tim_oc_en,
    input wire [7:0] tim_oc_val,
    // SPI.
    input wire spi_en,
    input wire spi_master,
    input wire spi_ss_out_en,
    input wire spi_sck_out,
    input wire spi_mosi_out,
    input wire spi_miso_out,
    input wire spi_ss_out,
    // CAN and serial interface.
    input wire can_present,
    input wire can_en,
    input wire can_tx,
    input wire sci_tx_en,
    input wire sci_rx_en,
    input wire sci_tx,
    // Pads.
    output reg [7:0] pad_p_out,
    output reg [7:0] pad_p_oe,
    output reg [7:6] pad_j_out,
    output reg [7:6] pad_j_oe,
    output reg [5:0] pad_m_out,
    output reg [5:0] pad_m_oe,
    output reg [3:0] pad_s_out,
    output reg [3:0] pad_s_oe,
    output reg [7:0] pad_t_out,
    output reg [7:0] pad_t_oe,
    // Peripheral inputs and status.
    output reg [7:0] keypad_wake_p,
    output reg [7:6] keypad_wake_j,
    output reg [7:0] timer_channel_pin,
    output reg spi_sck_in,
    output reg spi_mosi_in,
    output reg spi_miso_in,
    output reg spi_ss_in,
    output reg can_receive_pin,
    output reg sci_rx,
    output reg flash_visible_bit
);

// ----------------------------------------------------------------------------
// Strap decode
// ----------------------------------------------------------------------------
function strap_visible;
    input [2:0] m;
    input s;
    begin
        case (m)
            `PPFM_MODE_EMUL_NARROW, `PPFM_MODE_EMUL_WIDE: strap_visible = ~s;
            `PPFM_MODE_NORMAL_NARROW, `PPFM_MODE_NORMAL_WIDE: strap_visible = s;
            `PPFM_MODE_SPECIAL_TEST: strap_visible = 1'h0;
            default: strap_visible = 1'h1;
        endcase
    end
endfunction

// The strap is caught on the first clock after reset release, then held.
reg strap_done_q;
always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        strap_done_q <= 1'h0;
        flash_visible_bit <= `PPFM_FLASH_VISIBLE_RST;
    end else if (!strap_done_q) begin
        strap_done_q <= 1'h1;
        flash_visible_bit <= strap_visible(mode, pad_p_in[`PPFM_STRAP_BIT]);
    end
end

// ----------------------------------------------------------------------------
// Pin routing
// ----------------------------------------------------------------------------
reg [5:0] m_out_d;
reg [5:0] m_oe_d;
reg [3:0] s_out_d;
reg [3:0] s_oe_d;
wire [7:0] p_out_d;
wire [7:0] p_oe_d;
wire [7:0] t_out_d;
wire [7:0] t_oe_d;
wire [7:0] wake_p_d;
wire [7:6] wake_j_d;
genvar g;

// Returns the pair of enable and level: an enabled peripheral owns the pin, otherwise general I/O does.
function [1:0] pin_pick;
    input fn_en;
    input fn_oe;
    input fn_out;
    input gp_oe;
    input gp_out;
    begin
        if (fn_en) begin
            pin_pick = {fn_oe, fn_out};
        end else begin
            pin_pick = {gp_oe, gp_out};
        end
    end
endfunction

// Port P bits 5:0 can carry the pulse-width channel of the same index.
generate
    for (g = 0; g < 8; g = g + 1) begin : g_port_p
        if (g < 6) begin : g_pw
            assign {p_oe_d[g], p_out_d[g]} = pin_pick(pwp_en[g], 1'h1, pulse_width_out[g],
                gp_p_dir[g], gp_p_data[g]);
        end else begin : g_gp
            assign {p_oe_d[g], p_out_d[g]} = {gp_p_dir[g], gp_p_data[g]};
        end
    end
endgenerate

// Port T puts the timer channel under the pulse-width channel, which wins on bits 4:0.
generate
    for (g = 0; g < 8; g = g + 1) begin : g_port_t
        wire [1:0] tim_pick;
        assign tim_pick = pin_pick(tim_en[g], tim_oc_en[g], tim_oc_val[g], gp_t_dir[g], gp_t_data[g]);
        if (g < 5) begin : g_pw
            assign {t_oe_d[g], t_out_d[g]} = pin_pick(pwt_en[g], 1'h1, pulse_width_out[g],
                tim_pick[1], tim_pick[0]);
        end else begin : g_tim
            assign {t_oe_d[g], t_out_d[g]} = tim_pick;
        end
    end
endgenerate

// ----------------------------------------------------------------------------
// Keypad wake
// ----------------------------------------------------------------------------
// A wake request needs the pin to be an input, the wake enabled and the key pulling the pad low.
generate
    for (g = 0; g < 8; g = g + 1) begin : g_wake_p
        assign wake_p_d[g] = keypad_wake_p_en[g] & ~p_oe_d[g] & ~pad_p_in[g];
    end
    for (g = 6; g < 8; g = g + 1) begin : g_wake_j
        assign wake_j_d[g] = keypad_wake_j_en[g] & ~gp_j_dir[g] & ~pad_j_in[g];
    end
endgenerate

// ----------------------------------------------------------------------------
// Port M routing
// ----------------------------------------------------------------------------
always @* begin
    m_out_d = gp_m_data;
    m_oe_d = gp_m_dir;
    if (spi_en) begin
        m_out_d[5] = spi_sck_out;
        m_oe_d[5] = spi_master;
        m_out_d[4] = spi_mosi_out;
        m_oe_d[4] = spi_master;
        m_out_d[3] = spi_ss_out;
        m_oe_d[3] = spi_master & spi_ss_out_en;
        m_out_d[2] = spi_miso_out;
        m_oe_d[2] = ~spi_master;
    end
    if (can_present && can_en) begin
        m_out_d[1] = can_tx;
        m_oe_d[1] = 1'h1;
        m_oe_d[0] = 1'h0;
    end
end

// ----------------------------------------------------------------------------
// Port S routing
// ----------------------------------------------------------------------------
always @* begin
    s_out_d = gp_s_data;
    s_oe_d = gp_s_dir;
    if (sci_tx_en) begin
        s_out_d[1] = sci_tx;
        s_oe_d[1] = 1'h1;
    end
    if (sci_rx_en) begin
        s_oe_d[0] = 1'h0;
    end
end

// ----------------------------------------------------------------------------
// Pad registers
// ----------------------------------------------------------------------------
always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        pad_p_out <= 8'h00;
        pad_p_oe <= 8'h00;
        pad_j_out <= 2'h0;
        pad_j_oe <= 2'h0;
        pad_m_out <= 6'h00;
        pad_m_oe <= 6'h00;
        pad_s_out <= 4'h0;
        pad_s_oe <= 4'h0;
        pad_t_out <= 8'h00;
        pad_t_oe <= 8'h00;
    end else begin
        pad_p_out <= p_out_d;
        pad_p_oe <= p_oe_d;
        pad_j_out <= gp_j_data;
        pad_j_oe <= gp_j_dir;
        pad_m_out <= m_out_d;
        pad_m_oe <= m_oe_d;
        pad_s_out <= s_out_d;
        pad_s_oe <= s_oe_d;
        pad_t_out <= t_out_d;
        pad_t_oe <= t_oe_d;
    end
end

// ----------------------------------------------------------------------------
// Wake registers
// ----------------------------------------------------------------------------
always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        keypad_wake_p <= 8'h00;
        keypad_wake_j <= 2'h0;
    end else begin
        keypad_wake_p <= wake_p_d;
        keypad_wake_j <= wake_j_d;
    end
end

// ----------------------------------------------------------------------------
// Peripheral input registers
// ----------------------------------------------------------------------------
// Idle levels on reset keep the select and receive lines inactive.
always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        timer_channel_pin <= 8'h00;
        spi_sck_in <= 1'h0;
        spi_mosi_in <= 1'h0;
        spi_miso_in <= 1'h0;
        spi_ss_in <= 1'h1;
        can_receive_pin <= 1'h1;
        sci_rx <= 1'h1;
    end else begin
        timer_channel_pin <= pad_t_in & tim_en;
        spi_sck_in <= pad_m_in[5];
        spi_mosi_in <= pad_m_in[4];
        spi_ss_in <= pad_m_in[3];
        spi_miso_in <= pad_m_in[2];
        can_receive_pin <= (can_present & can_en) ? pad_m_in[0] : 1'h1;
        sci_rx <= sci_rx_en ? pad_s_in[0] : 1'h1;
    end
end

endmodule

// ### ppfm_regs.vh
// Constants for the port pin function multiplexer.
`ifndef PPFM_REGS_VH
`define PPFM_REGS_VH
`define PPFM_STRAP_BIT 6
`define PPFM_MODE_W 3
`define PPFM_MODE_SPECIAL_SINGLE 3'h0
`define PPFM_MODE_EMUL_NARROW 3'h1
`define PPFM_MODE_SPECIAL_TEST 3'h2
`define PPFM_MODE_EMUL_WIDE 3'h3
`define PPFM_MODE_NORMAL_SINGLE 3'h4
`define PPFM_MODE_NORMAL_NARROW 3'h5
`define PPFM_MODE_PERIPHERAL 3'h6
`define PPFM_MODE_NORMAL_WIDE 3'h7
`define PPFM_FLASH_VISIBLE_RST 1'h1
`endif

// ### ppfm_board.sv
// Board model that sets the pad levels seen by the multiplexer.
`timescale 1ns/1ps
module ppfm_board #(parameter W = 20) (
    input wire mclk,
    input wire [W-1:0] drv,
    input wire [W-1:0] oe,
    output reg [W-1:0] lvl
);
    initial lvl = {W{1'h0}};
    // A released pad shows the inverse of its last level, so a stale value never passes.
    always @(posedge mclk) begin
        lvl <= (drv & oe) | (~lvl & ~oe);
    end
endmodule

// ### ppfm_mux_chk.sv
// Checker for pad routing, keypad wake and strap capture.
`timescale 1ns/1ps
`include "ppfm_regs.vh"
module ppfm_chk (input wire mclk, rstn, input wire [2:0] mode, input wire [7:0] gp_p_dir, pad_p_in,
    keypad_wake_p_en, keypad_wake_p, pad_p_out, pad_p_oe, pad_t_out, pad_t_oe, tim_en,
    input wire [5:0] pwp_en, pulse_width_out, pad_m_out, pad_m_oe, input wire [4:0] pwt_en,
    input wire spi_en, spi_master, spi_mosi_out, flash_visible_bit);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_wk; !gp_p_dir[7] && keypad_wake_p_en[7] && !pad_p_in[7] |=> keypad_wake_p[7]; endproperty
    a_wk: assert property (p_wk) else $error("wake");
    property p_hd; $past(rstn, 2) |-> $stable(flash_visible_bit); endproperty
    a_hd: assert property (p_hd) else $error("strap hold");
    property p_ne; $rose(rstn) && mode == `PPFM_MODE_NORMAL_NARROW
        |=> flash_visible_bit == $past(pad_p_in[6]); endproperty
    a_ne: assert property (p_ne) else $error("strap normal");
    property p_sc; $rose(rstn) && mode == `PPFM_MODE_SPECIAL_SINGLE |=> flash_visible_bit; endproperty
    a_sc: assert property (p_sc) else $error("strap single");
    property p_pp; pwp_en[5] |=> pad_p_oe[5] && pad_p_out[5] == $past(pulse_width_out[5]); endproperty
    a_pp: assert property (p_pp) else $error("pwm p");
    property p_pt; pwt_en[0] && tim_en[0] |=> pad_t_oe[0] && pad_t_out[0] == $past(pulse_width_out[0]); endproperty
    a_pt: assert property (p_pt) else $error("pwm t");
    property p_mo; spi_en && spi_master |=> pad_m_oe[4] && pad_m_out[4] == $past(spi_mosi_out); endproperty
    a_mo: assert property (p_mo) else $error("mosi");
    property p_mi; spi_en && !spi_master |=> pad_m_oe[2]; endproperty
    a_mi: assert property (p_mi) else $error("miso");
    c_wk: cover property (keypad_wake_p[7]);
    c_pt: cover property (pwt_en[0] && tim_en[0]);
    c_st: cover property (!flash_visible_bit);
endmodule
bind ppfm_mux ppfm_chk u_ppfm_chk (.*);

// ### tb_top.sv
// Self-checking bench for the port pin function multiplexer.
`timescale 1ns/1ps
module tb_top;
    reg mclk = 1'h0, rstn = 1'h0, vld = 1'h0;
    reg [2:0] mode = 3'h0;
    reg [4:0] pe = 5'h0;
    reg [13:0] ex = 14'h0;
    reg [127:0] rv = 128'h0;
    integer seed = 32'hEA95050F, fails = 0, checks = 0, cyc = 0, i, m, k, k2;
    reg [55:0] e_pad = 56'h0;
    reg [23:0] e_in = 24'h0;
    reg [7:0] mp_o, mp_e, mt_o, mt_e;
    reg [5:0] mm_o, mm_e;
    reg [3:0] ms_o, ms_e;
    wire [7:0] gp_p_data, gp_p_dir, pad_p_in, gp_t_data, gp_t_dir, pad_t_in, keypad_wake_p_en, tim_en, tim_oc_en;
    wire [7:0] tim_oc_val, pad_p_out, pad_p_oe, pad_t_out, pad_t_oe, keypad_wake_p, timer_channel_pin;
    wire [7:6] gp_j_data, gp_j_dir, pad_j_in, keypad_wake_j_en, pad_j_out, pad_j_oe, keypad_wake_j;
    wire [5:0] gp_m_data, gp_m_dir, pad_m_in, pwp_en, pulse_width_out, pad_m_out, pad_m_oe;
    wire [3:0] gp_s_data, gp_s_dir, pad_s_in, pad_s_out, pad_s_oe;
    wire [4:0] pwt_en;
    wire spi_en, spi_master, spi_ss_out_en, spi_sck_out, spi_mosi_out, spi_miso_out, spi_ss_out, can_present, can_en;
    wire can_tx, sci_tx_en, sci_rx_en, sci_tx, spi_sck_in, spi_mosi_in, spi_miso_in, spi_ss_in, can_receive_pin;
    wire sci_rx, flash_visible_bit;
    assign {gp_p_data, gp_p_dir, gp_j_data, gp_j_dir, gp_m_data, gp_m_dir, gp_s_data, gp_s_dir, gp_t_data, gp_t_dir,
        keypad_wake_p_en, keypad_wake_j_en, pwp_en, pwt_en, pulse_width_out, tim_en, tim_oc_en, tim_oc_val, spi_en,
        spi_master, spi_ss_out_en, spi_sck_out, spi_mosi_out, spi_miso_out, spi_ss_out, can_present, can_en, can_tx,
        sci_tx_en, sci_rx_en, sci_tx, pad_p_in} = rv;
    ppfm_mux u_ppfm_mux (.*);
    ppfm_board u_ppfm_board (.mclk(mclk), .drv({pad_j_out, pad_m_out, pad_s_out, pad_t_out}),
        .oe({pad_j_oe, pad_m_oe, pad_s_oe, pad_t_oe}), .lvl({pad_j_in, pad_m_in, pad_s_in, pad_t_in}));
    always #5 mclk = ~mclk;
    task cmp_in(input [23:0] g, input [23:0] e);
        begin
            checks = checks + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("CHECK FAILED %0t %h %h", $time, g, e);
            end
        end
    endtask
    task cmp_strap(input g, input e);
        begin
            checks = checks + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("CHECK FAILED %0t %h %h", $time, g, e);
            end
        end
    endtask
    task cmp(input [55:0] g, input [55:0] e);
        begin
            checks = checks + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("CHECK FAILED %0t %h %h", $time, g, e);
            end
        end
    endtask
    task final_report;
        begin
            if (fails == 0 && checks > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    // ----------------------------------------------------------------
    // Random stimulus and one-cycle reference model.
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        rv <= {$random(seed), $random(seed), $random(seed), $random(seed)};
        ex <= {pwt_en, pulse_width_out[4:0] & pwt_en, gp_s_dir[3:2], gp_s_data[3:2]};
        pe <= pwt_en;
        vld <= rstn;
        for (k2 = 0; k2 < 8; k2 = k2 + 1) begin
            mp_o[k2] = (k2 < 6 && pwp_en[k2]) ? pulse_width_out[k2] : gp_p_data[k2];
            mp_e[k2] = (k2 < 6 && pwp_en[k2]) ? 1'b1 : gp_p_dir[k2];
            mt_o[k2] = (k2 < 5 && pwt_en[k2]) ? pulse_width_out[k2] : tim_en[k2] ? tim_oc_val[k2] : gp_t_data[k2];
            mt_e[k2] = (k2 < 5 && pwt_en[k2]) ? 1'b1 : tim_en[k2] ? tim_oc_en[k2] : gp_t_dir[k2];
        end
        mm_o = spi_en ? {spi_sck_out, spi_mosi_out, spi_ss_out, spi_miso_out, gp_m_data[1:0]} : gp_m_data;
        mm_e = spi_en ? {spi_master, spi_master, spi_master & spi_ss_out_en, !spi_master, gp_m_dir[1:0]} : gp_m_dir;
        if (can_present && can_en) begin
            mm_o[1] = can_tx;
            mm_e[1:0] = 2'b10;
        end
        ms_o = {gp_s_data[3:2], sci_tx_en ? sci_tx : gp_s_data[1], gp_s_data[0]};
        ms_e = {gp_s_dir[3:2], sci_tx_en | gp_s_dir[1], gp_s_dir[0] & !sci_rx_en};
        e_pad <= {mp_o, mp_e, gp_j_data, gp_j_dir, mm_o, mm_e, ms_o, ms_e, mt_o, mt_e};
        e_in <= {keypad_wake_p_en & ~mp_e & ~pad_p_in, keypad_wake_j_en & ~gp_j_dir & ~pad_j_in, pad_t_in & tim_en,
            pad_m_in[5:2], (can_present && can_en) ? pad_m_in[0] : 1'b1, sci_rx_en ? pad_s_in[0] : 1'b1};
        cyc = cyc + 1;
        if (cyc == 5000) begin
            fails = fails + 1;
            final_report;
        end
    end
    always @(negedge mclk) begin
        if (vld && rstn) begin
            cmp({pad_t_oe[4:0] & pe, pad_t_out[4:0] & pe, pad_s_oe[3:2], pad_s_out[3:2]}, ex);
            cmp({pad_p_out, pad_p_oe, pad_j_out, pad_j_oe, pad_m_out, pad_m_oe, pad_s_out, pad_s_oe, pad_t_out,
                pad_t_oe}, e_pad);
            cmp_in({keypad_wake_p, keypad_wake_j, timer_channel_pin, spi_sck_in, spi_mosi_in, spi_ss_in, spi_miso_in,
                can_receive_pin, sci_rx}, e_in);
        end
    end
    initial begin
        repeat (5) @(posedge mclk);
        for (i = 0; i < 16; i = i + 1) begin
            m = i % 8;
            rstn <= 1'h0;
            mode <= m[2:0];
            @(posedge mclk);
            rstn <= 1'h1;
            @(posedge mclk);
            k = (m == 1 || m == 3) ? !pad_p_in[6] : (m == 5 || m == 7) ? pad_p_in[6] : (m == 0 || m == 4 || m == 6);
            repeat (30) @(negedge mclk);
            cmp_strap(flash_visible_bit, k[0]);
        end
        final_report;
    end
endmodule
